//--- shared/mon_regs.svh
// register offsets, field positions, reset values and timing counts of the monitor handler
`ifndef MON_REGS_SVH
`define MON_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define MON_CTRL_OFS 8'hb0
`define MON_STAT_OFS 8'hb8
`define MON_TXD_OFS 8'hbc

// ----------------------------------------------------------------
// control register layout
// ----------------------------------------------------------------
`define MON_CTRL_W 19
`define MON_CTRL_RST 19'h000ff
`define MON_CTRL_SUB_LSB 12

// ----------------------------------------------------------------
// status register layout
// ----------------------------------------------------------------
`define MON_STAT_RXV_BIT 8
`define MON_STAT_RDY_BIT 9
`define MON_STAT_EMP_BIT 10
`define MON_STAT_VEC_LSB 11
`define MON_STAT_FND_BIT 14
`define MON_STAT_BUSY_BIT 15

// ----------------------------------------------------------------
// frame layout and timing counts
// ----------------------------------------------------------------
`define MON_EOM_FRAMES 2'h2
`define MON_MON_FIRST 5'h10
`define MON_MON_LAST 5'h17
`define MON_MX_POS 5'h1f

`endif

//--- shared/mon_pkg.sv
// types shared by the monitor-channel handler files
package mon_pkg;

    // control word as software sees it, msb first
    typedef struct packed {
        logic end_of_message_ctl;
        logic tx_fifo_reset;
        logic rx_section_reset;
        logic auto_search_enable;
        logic [2:0] subframe_select;
        logic rx_irq_mask;
        logic rx_on;
        logic tx_irq_mask;
        logic tx_on;
        logic [7:0] chan_mask;
    } ctrl_t;

    // serial bus pins seen by the handler
    typedef struct packed {
        logic dcl;
        logic fsc;
        logic rx_data;
    } link_in_t;

    // open-drain transmit data line
    typedef struct packed {
        logic tx_data;
        logic tx_oe;
    } link_out_t;

    // interrupt pulses towards the system interrupt logic
    typedef struct packed {
        logic as_event;
        logic [2:0] as_vector;
        logic rx_event;
        logic tx_event;
    } irq_t;

    // transmit sequencer states
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_SEND = 3'b010,
        TX_EOM = 3'b100
    } tx_state_t;

endpackage : mon_pkg

//--- logic/mon_fifo.sv
// small flop-based fifo with valid/ready on both sides
`timescale 1ns/1ps
module mon_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_clr,
    // fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_C = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_reg [DEPTH]; // storage flops
    logic [AW-1:0] wr_ptr_reg; // next slot to fill
    logic [AW-1:0] rd_ptr_reg; // oldest word
    logic [CW-1:0] count_reg; // words held

    // pointer advance with wrap for any depth
    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == LAST_C) ? '0 : p + 1'b1;
    endfunction : ptr_inc

    wire push = i_in_valid & o_in_ready;
    wire pop = o_out_valid & i_out_ready;

    assign o_in_ready = (count_reg != FULL_C);
    assign o_out_valid = (count_reg != '0);
    assign o_out_data = mem_reg[rd_ptr_reg];

    // pointers and level; clear drops everything held
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else if (i_clr) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) wr_ptr_reg <= ptr_inc(wr_ptr_reg);
            if (pop) rd_ptr_reg <= ptr_inc(rd_ptr_reg);
            count_reg <= count_reg + CW'(push) - CW'(pop);
        end
    end

    // data storage, no reset needed
    always_ff @(posedge i_clk) begin
        if (push) mem_reg[wr_ptr_reg] <= i_in_data;
    end

endmodule : mon_fifo

//--- logic/mon_handler.sv
// monitor-channel handler: control register, serial slot engine and transmit fifo
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "mon_regs.svh"

// Overview of operation
// - empty fifo, eom 0: two frames handshake high
// - eom 1: bytes stream on, no message end
// - fifo reset clears fifo, holds transmitter
// - receive reset holds receiver initial
// - receive reset also holds the transmitter
// - no auto-search: serve selected subframe only
// - auto-search: report first active subframe number
// - three-bit field selects one of eight
// - receiver mask suppresses receiver interrupts
// - receiver control switches receiver on/off
// - transmitter mask suppresses transmitter interrupts
// - transmitter control switches transmitter on/off
module mon_handler #(
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // serial bus pins
    input wire mon_pkg::link_in_t i_link,
    output mon_pkg::link_out_t o_link,
    // interrupt pulses
    output mon_pkg::irq_t o_irq
);
    import mon_pkg::*;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    ctrl_t ctrl_reg; // control word
    logic rx_valid_reg; // a byte waits in rx_byte_reg
    logic [7:0] rx_byte_reg; // last received monitor byte
    logic as_found_reg; // auto-search has a hit
    logic [2:0] as_vec_reg; // subframe of that hit
    logic [31:0] rdata_reg; // read answer
    logic fifo_in_ready; // fifo can take a byte
    logic fifo_out_valid; // fifo holds a byte
    logic [7:0] fifo_out_data; // oldest byte
    tx_state_t tx_state_reg; // transmit sequencer
    tx_state_t tx_state_next;

    wire sel_ctrl = (i_addr == `MON_CTRL_OFS);
    wire sel_stat = (i_addr == `MON_STAT_OFS);
    wire sel_txd = (i_addr == `MON_TXD_OFS);
    wire ctrl_wr = i_wr & sel_ctrl;
    // a write to a full fifo is dropped; software polls the ready bit
    wire txd_push = i_wr & sel_txd;
    wire stat_rd = i_rd & sel_stat;

    // status word assembled from live state
    wire [31:0] stat_word = {16'h0000, (tx_state_reg != TX_IDLE), as_found_reg,
        as_vec_reg, ~fifo_out_valid, fifo_in_ready, rx_valid_reg, rx_byte_reg};
    // unmapped addresses and the write-only data port read as zero
    wire [31:0] rd_mux = sel_ctrl ? {13'h0000, ctrl_reg} : (sel_stat ? stat_word : 32'h0);
    wire [31:0] rdata_next = i_rd ? rd_mux : 32'h0;

    // control register write
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) ctrl_reg <= ctrl_t'(`MON_CTRL_RST);
        else if (ctrl_wr) ctrl_reg <= ctrl_t'(i_wdata[`MON_CTRL_W-1:0]);
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) rdata_reg <= 32'h0;
        else rdata_reg <= rdata_next;
    end
    assign o_rdata = rdata_reg;

    // ------------------------------------------------------------
    // pin synchronisers and frame timing
    // ------------------------------------------------------------
    logic [1:0] dcl_sync_reg; // stage 0 feeds stage 1 only
    logic [1:0] fsc_sync_reg;
    logic [1:0] rxd_sync_reg;
    logic dcl_prev_reg; // last synced clock level
    logic fsc_prev_reg; // sync level at last bit
    logic [7:0] bit_idx_reg; // bit index of last sampled bit

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dcl_sync_reg <= 2'h0;
            fsc_sync_reg <= 2'h0;
            rxd_sync_reg <= 2'h3;
        end else begin
            dcl_sync_reg <= {dcl_sync_reg[0], i_link.dcl};
            fsc_sync_reg <= {fsc_sync_reg[0], i_link.fsc};
            rxd_sync_reg <= {rxd_sync_reg[0], i_link.rx_data};
        end
    end

    wire dcl_s = dcl_sync_reg[1];
    wire fsc_s = fsc_sync_reg[1];
    wire rxd_s = rxd_sync_reg[1];
    wire dcl_rise = dcl_s & ~dcl_prev_reg;
    // a rising frame sync seen at a bit clock edge starts bit 0
    wire frame_start = dcl_rise & fsc_s & ~fsc_prev_reg;
    wire [7:0] cur_idx = frame_start ? 8'h00 : bit_idx_reg + 8'h01;
    wire [7:0] nxt_idx = cur_idx + 8'h01;
    wire [2:0] cur_sub = cur_idx[7:5];
    wire [4:0] cur_pos = cur_idx[4:0];
    wire [2:0] nxt_sub = nxt_idx[7:5];
    wire [4:0] nxt_pos = nxt_idx[4:0];

    // is a position inside the monitor byte of a subframe
    function automatic logic in_mon(input logic [4:0] pos);
        in_mon = (pos >= `MON_MON_FIRST) && (pos <= `MON_MON_LAST);
    endfunction : in_mon

    // bit counter advances only on link clock edges
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dcl_prev_reg <= 1'b0;
            fsc_prev_reg <= 1'b0;
            bit_idx_reg <= 8'hff;
        end else begin
            dcl_prev_reg <= dcl_s;
            if (dcl_rise) fsc_prev_reg <= fsc_s;
            if (dcl_rise) bit_idx_reg <= cur_idx;
        end
    end

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    logic [7:0] rx_shift_reg; // monitor byte being assembled

    // receiver live only when on and not in reset
    wire rx_active = ctrl_reg.rx_on & ~ctrl_reg.rx_section_reset;
    // handshake low at the end of a subframe marks an active channel
    wire mx_low = dcl_rise & (cur_pos == `MON_MX_POS) & ~rxd_s & rx_active;
    // fixed mode serves the selected subframe only
    wire rx_capture = mx_low & ~ctrl_reg.auto_search_enable &
        (cur_sub == ctrl_reg.subframe_select);
    // auto-search reports the first active subframe
    wire as_hit = mx_low & ctrl_reg.auto_search_enable & ~as_found_reg;

    // assemble msb first
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) rx_shift_reg <= 8'h00;
        else if (dcl_rise && in_mon(cur_pos)) rx_shift_reg <= {rx_shift_reg[6:0], rxd_s};
    end

    // reset holds receive state clear; capture beats a status read
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_valid_reg <= 1'b0;
            rx_byte_reg <= 8'h00;
        end else if (ctrl_reg.rx_section_reset) begin
            rx_valid_reg <= 1'b0;
            rx_byte_reg <= 8'h00;
        end else if (rx_capture) begin
            rx_valid_reg <= 1'b1;
            rx_byte_reg <= rx_shift_reg;
        end else if (stat_rd) begin
            rx_valid_reg <= 1'b0;
        end
    end

    // hit held until search is switched off or receive reset is set, so software can
    // load the number before reading
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            as_found_reg <= 1'b0;
            as_vec_reg <= 3'h0;
        end else if (ctrl_reg.rx_section_reset || !ctrl_reg.auto_search_enable) begin
            as_found_reg <= 1'b0;
        end else if (as_hit) begin
            as_found_reg <= 1'b1;
            as_vec_reg <= cur_sub;
        end
    end

    // ------------------------------------------------------------
    // transmit fifo and sequencer
    // ------------------------------------------------------------
    logic [7:0] tx_byte_reg; // byte on the line this frame
    logic [1:0] eom_cnt_reg; // end frames already sent
    logic tx_done; // message end completed

    // transmitter held by its reset, off, or receive reset
    wire tx_hold = ctrl_reg.tx_fifo_reset | ctrl_reg.rx_section_reset | ~ctrl_reg.tx_on;
    wire tx_idle = (tx_state_reg == TX_IDLE);
    wire tx_send = (tx_state_reg == TX_SEND);
    wire tx_eom = (tx_state_reg == TX_EOM);
    // one byte leaves per frame; the line stalls the fifo in between
    wire tx_pop = frame_start & fifo_out_valid & ~tx_hold & (tx_idle | tx_send);

    // fifo cleared while its reset is set
    mon_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_clr(ctrl_reg.tx_fifo_reset),
        .i_in_valid(txd_push),
        .o_in_ready(fifo_in_ready),
        .i_in_data(i_wdata[7:0]),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(tx_pop),
        .o_out_data(fifo_out_data)
    );

    // next state at frame boundaries
    always_comb begin
        tx_state_next = tx_state_reg;
        tx_done = 1'b0;
        if (tx_hold) begin
            tx_state_next = TX_IDLE;
        end else if (frame_start) begin
            unique case (tx_state_reg)
                TX_IDLE: begin
                    if (fifo_out_valid) tx_state_next = TX_SEND;
                end
                TX_SEND: begin
                    // empty fifo ends message only with eom at 0
                    if (fifo_out_valid) tx_state_next = TX_SEND;
                    else if (ctrl_reg.end_of_message_ctl) tx_state_next = TX_IDLE;
                    else tx_state_next = TX_EOM;
                end
                TX_EOM: begin
                    // second end frame completes the message
                    if (eom_cnt_reg == `MON_EOM_FRAMES - 2'h1) begin
                        tx_state_next = TX_IDLE;
                        tx_done = 1'b1;
                    end
                end
                default: tx_state_next = TX_IDLE;
            endcase
        end
    end

    // state, byte and end count return to initial when held
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_state_reg <= TX_IDLE;
            tx_byte_reg <= 8'hff;
            eom_cnt_reg <= 2'h0;
        end else begin
            tx_state_reg <= tx_state_next;
            if (tx_hold) tx_byte_reg <= 8'hff;
            else if (tx_pop) tx_byte_reg <= fifo_out_data;
            if (tx_state_next != TX_EOM) eom_cnt_reg <= 2'h0;
            else if (frame_start && tx_eom) eom_cnt_reg <= eom_cnt_reg + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // line driver: bit for the next position is set up at each rising link clock edge
    // ------------------------------------------------------------
    logic tx_data_reg; // line level driven
    logic tx_oe_reg; // driving the line

    // only the selected subframe's monitor byte and handshake
    wire nxt_slot = (nxt_sub == ctrl_reg.subframe_select) &
        (in_mon(nxt_pos) | (nxt_pos == `MON_MX_POS));
    // end frames keep the handshake bit high, data idle
    wire nxt_bit = (nxt_pos == `MON_MX_POS) ? ~tx_send :
        (tx_send ? tx_byte_reg[3'h7 - nxt_pos[2:0]] : 1'b1);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_data_reg <= 1'b1;
            tx_oe_reg <= 1'b0;
        end else if (tx_hold) begin
            tx_data_reg <= 1'b1;
            tx_oe_reg <= 1'b0;
        end else if (dcl_rise) begin
            tx_data_reg <= nxt_bit;
            tx_oe_reg <= nxt_slot & (tx_send | tx_eom);
        end
    end
    assign o_link.tx_data = tx_data_reg;
    assign o_link.tx_oe = tx_oe_reg;

    // ------------------------------------------------------------
    // interrupt pulses, gated by the mask at the event
    // ------------------------------------------------------------
    irq_t irq_reg;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_reg <= '0;
        end else begin
            irq_reg.rx_event <= rx_capture & ~ctrl_reg.rx_irq_mask;
            irq_reg.as_event <= as_hit & ~ctrl_reg.rx_irq_mask;
            irq_reg.tx_event <= tx_done & ~ctrl_reg.tx_irq_mask;
            if (as_hit) irq_reg.as_vector <= cur_sub;
        end
    end
    assign o_irq = irq_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    eom_two_frames_a: assert property (
        (tx_eom && frame_start && eom_cnt_reg == 2'h1 && !tx_hold)
        |=> tx_idle && (o_irq.tx_event == !$past(ctrl_reg.tx_irq_mask)))
        else $error("message end not after two frames");
    eom_stream_a: assert property (
        (tx_send && frame_start && !fifo_out_valid && ctrl_reg.end_of_message_ctl
        && !tx_hold) |=> tx_idle)
        else $error("end frames sent in streaming mode");
    fifo_reset_a: assert property (
        ctrl_reg.tx_fifo_reset |=> tx_idle && !fifo_out_valid && !o_link.tx_oe)
        else $error("fifo reset did not clear transmitter");
    rx_reset_a: assert property (
        ctrl_reg.rx_section_reset |=> !rx_valid_reg && !as_found_reg)
        else $error("receiver not held in reset");
    rx_holds_tx_a: assert property (
        ctrl_reg.rx_section_reset |=> tx_idle && !o_link.tx_oe)
        else $error("receive reset did not hold transmitter");
    fixed_channel_a: assert property (
        (rx_valid_reg && !$past(rx_valid_reg)) |-> $past(!ctrl_reg.auto_search_enable
        && cur_sub == ctrl_reg.subframe_select))
        else $error("capture outside selected subframe");
    search_vector_a: assert property (
        as_hit |=> as_found_reg && as_vec_reg == $past(cur_sub) && o_irq.as_vector == as_vec_reg)
        else $error("auto-search vector wrong");
    drive_slot_a: assert property (
        (dcl_rise && !tx_hold && (tx_send || tx_eom) && nxt_slot) |=> o_link.tx_oe)
        else $error("selected slot not driven");
    rx_mask_a: assert property (
        (o_irq.rx_event || o_irq.as_event) |-> !$past(ctrl_reg.rx_irq_mask))
        else $error("masked receiver interrupt posted");
    rx_off_a: assert property (
        !ctrl_reg.rx_on |=> !o_irq.rx_event && !o_irq.as_event)
        else $error("receiver active while off");
    tx_mask_a: assert property (
        o_irq.tx_event |-> !$past(ctrl_reg.tx_irq_mask))
        else $error("masked transmitter interrupt posted");
    tx_off_a: assert property (
        !ctrl_reg.tx_on |=> !o_link.tx_oe && tx_idle)
        else $error("transmitter active while off");
    mask_at_event_a: assert property (
        (rx_capture && !ctrl_reg.rx_irq_mask) |=> o_irq.rx_event)
        else $error("unmasked receive event lost");

    byte_sent_c: cover property (tx_pop);
    message_end_c: cover property (tx_done);
    byte_received_c: cover property (rx_capture);
    search_hit_c: cover property (as_hit);

endmodule : mon_handler

//--- dv/serial_peer.sv
// peer transceiver model: bit clock, frame sync, receive data, tx listener
`timescale 1ns/1ps
module serial_peer import mon_pkg::*; (
    // pins towards the handler
    output mon_pkg::link_in_t o_link,
    input wire mon_pkg::link_out_t i_link,
    // what the peer sends and in which subframe
    input wire logic i_act,
    input wire logic [2:0] i_sub,
    input wire logic [7:0] i_byte,
    // what the peer heard
    output logic [7:0] o_txbyte,
    output logic [2:0] o_txsub,
    output int o_ends
);
    logic [7:0] pos = 8'hff; // bit position in frame
    logic [7:0] sh = 8'h00; // tx byte shifter
    logic [4:0] bp; // position in subframe
    logic hit; // inside our active subframe
    initial begin
        o_link = '{dcl: 1'b0, fsc: 1'b0, rx_data: 1'b1};
        o_txbyte = 8'h00;
        o_txsub = 3'h0;
        o_ends = 0;
    end
    // the frame bus clock runs free, frames never stop it
    always #40 o_link.dcl = ~o_link.dcl;
    // next bit set up on the falling edge, away from the sampling edge
    always @(negedge o_link.dcl) begin
        pos = pos + 8'h01;
        bp = pos[4:0];
        hit = i_act && (pos[7:5] == i_sub);
        o_link.fsc = (pos == 8'h00);
        // released line rests at its pull-up level
        o_link.rx_data = 1'b1;
        if (hit && bp >= 5'h10 && bp <= 5'h17) o_link.rx_data = i_byte[5'h17 - bp];
        if (hit && bp == 5'h1f) o_link.rx_data = 1'b0;
    end
    // tx bits are settled by the next rising edge
    always @(posedge o_link.dcl) begin
        if (i_link.tx_oe === 1'b1) begin
            if (pos[4:0] >= 5'h10 && pos[4:0] <= 5'h17) sh = {sh[6:0], i_link.tx_data};
            if (pos[4:0] == 5'h1f && i_link.tx_data === 1'b0) begin
                o_txbyte = sh;
                o_txsub = pos[7:5];
            end
            if (pos[4:0] == 5'h1f && i_link.tx_data === 1'b1) o_ends++;
        end
    end
endmodule : serial_peer

//--- dv/mon_handler_tb_top.sv
// self-checking bench for the monitor-channel handler
`timescale 1ns/1ps
module mon_handler_tb_top;
    import mon_pkg::*;
    logic i_clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0, rd_d = 1'b0, act = 1'b0;
    logic [7:0] i_addr = 8'h00, byt = 8'h00, txb, b;
    logic [31:0] i_wdata = 32'h0, o_rdata, d;
    logic [2:0] sub = 3'h0, txs, as_vec = 3'h0;
    link_in_t i_link;
    link_out_t o_link;
    irq_t o_irq;
    int bad_count = 0, num_checks = 0, cyc = 0, n_rx = 0, n_as = 0, n_tx = 0, ends;
    logic [31:0] exp_q[$]; // expected read data, oldest first
    logic [31:0] quiet[4] = '{32'h3c00, 32'h3000, 32'h13400, 32'h2400};

    mon_handler #(.FIFO_DEPTH(8)) dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_link(i_link),
        .o_link(o_link), .o_irq(o_irq));
    serial_peer peer (.o_link(i_link), .i_link(o_link), .i_act(act), .i_sub(sub),
        .i_byte(byt), .o_txbyte(txb), .o_txsub(txs), .o_ends(ends));

    initial begin
        forever #5 i_clk = ~i_clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        i_addr <= a;
        i_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(posedge i_clk);
    endtask : rd

    // one frame is 256 bits of 80 ns, 2048 clocks
    task automatic frames(input int n);
        repeat (n * 2048) @(posedge i_clk);
    endtask : frames

    // watcher: read data the cycle after the strobe, event pulses, hang limit
    always @(posedge i_clk) begin
        rd_d <= i_rd;
        if (rd_d) chk(o_rdata, exp_q.pop_front(), "rdata");
        if (o_irq.rx_event === 1'b1) n_rx++;
        if (o_irq.tx_event === 1'b1) n_tx++;
        if (o_irq.as_event === 1'b1) n_as++;
        if (o_irq.as_event === 1'b1) as_vec = o_irq.as_vector;
        cyc++;
        if (cyc > 90000) begin
            bad_count++;
            test_done();
        end
    end

    initial begin
        void'($urandom(32'hfbfd));
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        // registers: reset value, unmapped place, random readback
        rd(8'hb0, 32'h000000ff);
        rd(8'ha0, 32'h0);
        d = $urandom & 32'h77aff;
        wr(8'hb0, d);
        rd(8'hb0, d);
        $display("test regs done");
        // byte then two frames of message end in subframe 2
        b = 8'($urandom_range(255));
        wr(8'hb0, 32'h2100);
        wr(8'hbc, {24'h0, b});
        frames(5);
        chk(txb, b, "tx byte");
        chk(txs, 3'h2, "tx subframe");
        chk(ends, 2, "end frames");
        chk(n_tx, 1, "tx events");
        // masked message end: end frames still on the line, no event
        wr(8'hb0, 32'h2300);
        wr(8'hbc, 32'h5a);
        frames(5);
        chk(ends, 4, "masked end frames");
        chk(n_tx, 1, "masked tx event");
        $display("test eom done");
        // streaming, fifo reset, receive reset holding tx
        wr(8'hb0, 32'h42100);
        wr(8'hbc, 32'hb2);
        frames(3);
        chk(txb, 8'hb2, "stream byte");
        wr(8'hb0, 32'h62100);
        wr(8'hbc, 32'h33);
        frames(2);
        wr(8'hb0, 32'h52100);
        wr(8'hbc, 32'hc3);
        frames(2);
        chk(txb, 8'hb2, "held tx");
        wr(8'hb0, 32'h42100);
        frames(2);
        chk(txb, 8'hc3, "released tx");
        chk(ends, 4, "no message end");
        chk(n_tx, 1, "no tx event");
        $display("test stream done");
        // receive in subframe 3, then four setups that must stay silent
        byt <= 8'($urandom_range(255));
        sub <= 3'h3;
        act <= 1'b1;
        wr(8'hb0, 32'h3400);
        frames(2);
        chk(32'(n_rx != 0), 32'h1, "rx events");
        rd(8'hb8, 32'h700 | byt);
        for (int k = 0; k < 4; k++) begin
            wr(8'hb0, quiet[k]);
            @(posedge i_clk);
            n_rx = 0;
            frames(2);
            chk(n_rx, 0, "quiet rx");
        end
        $display("test rx done");
        // auto-search finds the active subframe, software then selects it
        sub <= 3'($urandom_range(7));
        wr(8'hb0, 32'h8400);
        frames(2);
        chk(n_as, 1, "search events");
        chk(as_vec, sub, "search vector");
        // found number written into the subframe field
        wr(8'hb0, {16'h0, 1'b0, as_vec, 12'h400});
        rd(8'hb0, {16'h0, 1'b0, sub, 12'h400});
        $display("test search done");
        test_done();
    end
endmodule : mon_handler_tb_top
